/* File: rtl/igp_pkg.sv */
// Constants, register map and state encoding shared by the inverter gate protection logic.
package igp_pkg;

   // Clock and protection timing.
   localparam int unsigned CLK_PERIOD_NS    = 8;
   localparam int unsigned FAULT_MIN_NS     = 20000;
   // A least time rounds up so the fault pulse never falls short.
   localparam int unsigned FAULT_MIN_CYC    = (FAULT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned FAULT_CNT_W      = $clog2(FAULT_MIN_CYC + 1);
   localparam int unsigned CMD_MIN_PULSE_NS = 700;
   localparam int unsigned CMD_MIN_PULSE_CYC =
      (CMD_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Number of inverter legs.
   localparam int unsigned PHASES = 3;

   // Width of the pin bundle passed through the synchroniser.
   localparam int unsigned SYNC_W = 13;
   // Bit positions inside the synchronised pin bundle.
   localparam int unsigned SY_HI  = 0;
   localparam int unsigned SY_LO  = 3;
   localparam int unsigned SY_SC  = 6;
   localparam int unsigned SY_LUV = 7;
   localparam int unsigned SY_OT  = 8;
   localparam int unsigned SY_HUV = 9;
   localparam int unsigned SY_PIN = 12;

   // Register byte offsets on the Wishbone bus.
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_STATUS   = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ_MASK = 8'h0C;

   // Control register fields and reset value.
   localparam int unsigned CTRL_EN_BIT = 0;
   localparam logic        CTRL_EN_RST = 1'h0;

   // Event bits, shared by the interrupt status and mask registers.
   localparam int unsigned EV_W   = 6;
   localparam int unsigned EV_SC  = 0;
   localparam int unsigned EV_LUV = 1;
   localparam int unsigned EV_OT  = 2;
   localparam int unsigned EV_HUV = 3;
   localparam logic [EV_W-1:0] IRQ_MASK_RST = 6'h00;

   // Live status register fields.
   localparam int unsigned ST_PULSE   = 0;
   localparam int unsigned ST_LUV     = 1;
   localparam int unsigned ST_OT      = 2;
   localparam int unsigned ST_HUV     = 3;
   localparam int unsigned ST_FAULT   = 6;
   localparam int unsigned ST_PIN     = 7;
   localparam int unsigned ST_LO_LOCK = 8;
   localparam int unsigned ST_HI_LOCK = 11;

   // Fault output sequencer, Gray coded along idle, pulse, hold.
   typedef enum logic [1:0] {
      FLT_IDLE  = 2'h0,
      FLT_PULSE = 2'h1,
      FLT_HOLD  = 2'h3
   } igp_flt_t;

endpackage

/* File: rtl/igp_sync.sv */
// Two flip-flop synchroniser for a bundle of asynchronous pin levels.
`timescale 1ns/1ns
`default_nettype none
module igp_sync #(
   parameter int unsigned WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // Asynchronous levels in, synchronised levels out
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // The first stage feeds only the second; nothing else may look at it.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= d_i;
         sync_q <= meta_q;
      end
   end

   assign q_o = sync_q;

endmodule
`default_nettype wire

/* File: rtl/igp_top.sv */
// Gate control and protection logic of a three-phase inverter module, with a Wishbone register port.
//
// What this block does
// - A short circuit forces all three low-side gates off at once, whatever the commands.
// - Short circuit drives the fault pin for at least 20 us; low side stays off after.
// - After any shutdown each phase resumes only on a rising edge of its own command.
// - Low-side supply under-voltage forces all low-side gates off, whatever the commands.
// - Low-side under-voltage holds the fault pin at least 20 us and while it lasts.
// - After low-side supply recovery, a low gate turns on only at the next command edge.
// - High-side under-voltage forces only that phase's high gate off, without fault signalling.
// - After high-side supply recovery, that high gate turns on only at the next command edge.
// - Over-temperature forces all low-side gates off, whatever the commands.
// - Over-temperature holds the fault pin at least 20 us and while the condition lasts.
// - After over-temperature clears, low gates resume only at the next command edge.
// - Commands are active high; a high level asks for the switch on, undriven means off.
// - Fault pin is active for all three low-side protections: fixed for short circuit.
//
// Design decisions made here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module igp_top (
   // Clock and reset
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   // Wishbone slave
   input  wire logic [7:0]                 wb_adr_i,
   input  wire logic [31:0]                wb_dat_i,
   input  wire logic [3:0]                 wb_sel_i,
   input  wire logic                       wb_we_i,
   input  wire logic                       wb_cyc_i,
   input  wire logic                       wb_stb_i,
   output logic      [31:0]                wb_dat_o,
   output logic                            wb_ack_o,
   // Switch commands from the controller, index 0 is phase a
   input  wire logic [igp_pkg::PHASES-1:0] high_cmd_i,
   input  wire logic [igp_pkg::PHASES-1:0] low_cmd_i,
   // Protection detector levels
   input  wire logic                       short_circuit_trip_i,
   input  wire logic                       low_supply_uv_i,
   input  wire logic                       over_temp_trip_i,
   input  wire logic [igp_pkg::PHASES-1:0] high_supply_uv_i,
   // Open-drain active-low fault pin
   input  wire logic                       fault_out_n_i,
   output logic                            fault_out_n_o,
   output logic                            fault_out_n_oe_o,
   // Gate drives
   output logic      [igp_pkg::PHASES-1:0] gate_high_o,
   output logic      [igp_pkg::PHASES-1:0] gate_low_o,
   // Interrupt
   output logic                            irq_o
);

   localparam int unsigned P  = igp_pkg::PHASES;
   localparam int unsigned CW = igp_pkg::FAULT_CNT_W;

   // Synchronised pins and their previous values.
   logic [igp_pkg::SYNC_W-1:0] pins_s;
   logic [igp_pkg::SYNC_W-2:0] prev_q;
   logic [igp_pkg::SYNC_W-2:0] prev_d;
   logic [P-1:0]               hi_s;
   logic [P-1:0]               lo_s;
   logic [P-1:0]               huv_s;
   logic                       sc_s;
   logic                       luv_s;
   logic                       ot_s;
   logic                       pin_s;
   logic [P-1:0]               hi_rise;
   logic [P-1:0]               lo_rise;
   logic [P-1:0]               huv_rise;
   logic                       sc_rise;
   logic                       luv_rise;
   logic                       ot_rise;

   // Protection state.
   igp_pkg::igp_flt_t flt_q;
   igp_pkg::igp_flt_t flt_d;
   logic [CW-1:0]     cnt_q;
   logic [CW-1:0]     cnt_d;
   logic [P-1:0]      lo_lock_q;
   logic [P-1:0]      lo_lock_d;
   logic [P-1:0]      hi_lock_q;
   logic [P-1:0]      hi_lock_d;
   logic [P-1:0]      gate_high_q;
   logic [P-1:0]      gate_high_d;
   logic [P-1:0]      gate_low_q;
   logic [P-1:0]      gate_low_d;
   logic              fault_oe_q;
   logic              fault_oe_d;
   logic              lo_force;
   logic              trigger;

   // Register state.
   logic                      ctrl_en_q;
   logic                      ctrl_en_d;
   logic [igp_pkg::EV_W-1:0]  irq_stat_q;
   logic [igp_pkg::EV_W-1:0]  irq_stat_d;
   logic [igp_pkg::EV_W-1:0]  irq_mask_q;
   logic [igp_pkg::EV_W-1:0]  irq_mask_d;
   logic [igp_pkg::EV_W-1:0]  events;
   logic                      irq_q;
   logic                      irq_d;
   logic [31:0]               dat_q;
   logic [31:0]               dat_d;
   logic                      ack_q;
   logic                      ack_d;
   logic                      fault_pin_q;
   logic [31:0]               status;
   logic [31:0]               wmask;
   logic                      wr;
   logic                      req;

   // Every pin and detector level crosses into the clock domain through two flops.
   igp_sync #(
      .WIDTH (igp_pkg::SYNC_W)
   ) u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   ({fault_out_n_i, high_supply_uv_i, over_temp_trip_i, low_supply_uv_i,
               short_circuit_trip_i, low_cmd_i, high_cmd_i}),
      .q_o   (pins_s)
   );

   // Split the synchronised bundle; the external pull-down keeps an open command low.
   assign hi_s  = pins_s[igp_pkg::SY_HI +: P];
   assign lo_s  = pins_s[igp_pkg::SY_LO +: P];
   assign huv_s = pins_s[igp_pkg::SY_HUV +: P];
   assign sc_s  = pins_s[igp_pkg::SY_SC];
   assign luv_s = pins_s[igp_pkg::SY_LUV];
   assign ot_s  = pins_s[igp_pkg::SY_OT];
   assign pin_s = pins_s[igp_pkg::SY_PIN];

   // Rising edges are taken only from synchronised levels and their delayed copies.
   assign prev_d   = pins_s[igp_pkg::SYNC_W-2:0];
   assign hi_rise  = hi_s & ~prev_q[igp_pkg::SY_HI +: P];
   assign lo_rise  = lo_s & ~prev_q[igp_pkg::SY_LO +: P];
   assign huv_rise = huv_s & ~prev_q[igp_pkg::SY_HUV +: P];
   assign sc_rise  = sc_s & ~prev_q[igp_pkg::SY_SC];
   assign luv_rise = luv_s & ~prev_q[igp_pkg::SY_LUV];
   assign ot_rise  = ot_s & ~prev_q[igp_pkg::SY_OT];

   // Any low-side protection active now forces all low gates off.
   assign lo_force = sc_s | luv_s | ot_s;

   // A new short circuit always restarts the pulse; a standing condition starts one from idle.
   assign trigger = sc_rise | ((luv_s | ot_s) & (flt_q == igp_pkg::FLT_IDLE));

   // Fault pulse sequencer and minimum-width counter.
   always_comb begin
      flt_d = flt_q;
      cnt_d = cnt_q;
      if (trigger) begin
         flt_d = igp_pkg::FLT_PULSE;
         cnt_d = CW'(igp_pkg::FAULT_MIN_CYC);
      end else begin
         case (flt_q)
            igp_pkg::FLT_PULSE: begin
               cnt_d = cnt_q - CW'(1);
               if (cnt_q == CW'(1)) begin
                  // Short circuit ends here; the levels extend the pulse.
                  if (luv_s | ot_s) begin
                     flt_d = igp_pkg::FLT_HOLD;
                  end else begin
                     flt_d = igp_pkg::FLT_IDLE;
                  end
               end
            end
            igp_pkg::FLT_HOLD: begin
               if (!(luv_s | ot_s)) begin
                  flt_d = igp_pkg::FLT_IDLE;
               end
            end
            default: begin
               flt_d = igp_pkg::FLT_IDLE;
            end
         endcase
      end
   end

   // High-side under-voltage takes no part in fault signalling.
   assign fault_oe_d = (flt_d != igp_pkg::FLT_IDLE);

   // Per-phase lockouts and gate drives. Set wins over a re-arm edge in the same cycle.
   always_comb begin
      lo_lock_d   = lo_lock_q;
      hi_lock_d   = hi_lock_q;
      gate_low_d  = '0;
      gate_high_d = '0;
      for (int i = 0; i < P; i++) begin
         // Low side re-arms only when every protection is gone and the pulse has ended.
         if (lo_force || !ctrl_en_q) begin
            lo_lock_d[i] = 1'b1;
         end else if (lo_rise[i] && flt_q == igp_pkg::FLT_IDLE) begin
            lo_lock_d[i] = 1'b0;
         end
         // High side is locked only for its own phase.
         if (huv_s[i] || !ctrl_en_q) begin
            hi_lock_d[i] = 1'b1;
         end else if (hi_rise[i]) begin
            hi_lock_d[i] = 1'b0;
         end
         gate_low_d[i]  = lo_s[i] & ~lo_lock_d[i];
         gate_high_d[i] = hi_s[i] & ~hi_lock_d[i];
      end
   end

   // Protection registers. Locks start set so no gate turns on without a fresh edge.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_q      <= '0;
         flt_q       <= igp_pkg::FLT_IDLE;
         cnt_q       <= '0;
         lo_lock_q   <= '1;
         hi_lock_q   <= '1;
         gate_low_q  <= '0;
         gate_high_q <= '0;
         fault_oe_q  <= 1'b0;
      end else begin
         prev_q      <= prev_d;
         flt_q       <= flt_d;
         cnt_q       <= cnt_d;
         lo_lock_q   <= lo_lock_d;
         hi_lock_q   <= hi_lock_d;
         gate_low_q  <= gate_low_d;
         gate_high_q <= gate_high_d;
         fault_oe_q  <= fault_oe_d;
      end
   end

   // The open-drain pin only ever pulls low; its level register never leaves zero.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fault_pin_q <= 1'b0;
      end else begin
         fault_pin_q <= 1'b0;
      end
   end

   // Events for the interrupt status register.
   assign events[igp_pkg::EV_SC]           = sc_rise;
   assign events[igp_pkg::EV_LUV]          = luv_rise;
   assign events[igp_pkg::EV_OT]           = ot_rise;
   assign events[igp_pkg::EV_HUV +: P]     = huv_rise;

   // Live status view.
   always_comb begin
      status                                 = '0;
      status[igp_pkg::ST_PULSE]              = (flt_q == igp_pkg::FLT_PULSE);
      status[igp_pkg::ST_LUV]                = luv_s;
      status[igp_pkg::ST_OT]                 = ot_s;
      status[igp_pkg::ST_HUV +: P]           = huv_s;
      status[igp_pkg::ST_FAULT]              = fault_oe_q;
      status[igp_pkg::ST_PIN]                = ~pin_s;
      status[igp_pkg::ST_LO_LOCK +: P]       = lo_lock_q;
      status[igp_pkg::ST_HI_LOCK +: P]       = hi_lock_q;
   end

   // Bus request decode; ack falls in the cycle after it was given.
   assign req   = wb_cyc_i & wb_stb_i & ~ack_q;
   assign wr    = req & wb_we_i;
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}}
                  & wb_dat_i;

   // Register writes and reads. A hardware event in the clearing cycle stays set.
   always_comb begin
      ctrl_en_d  = ctrl_en_q;
      irq_mask_d = irq_mask_q;
      irq_stat_d = irq_stat_q;
      dat_d      = dat_q;
      ack_d      = req;
      if (wr && wb_adr_i[7:2] == igp_pkg::REG_CTRL[7:2]) begin
         ctrl_en_d = wmask[igp_pkg::CTRL_EN_BIT] |
                     (ctrl_en_q & ~wb_sel_i[0]);
      end else if (wr && wb_adr_i[7:2] == igp_pkg::REG_IRQ_STAT[7:2]) begin
         irq_stat_d = irq_stat_q & ~wmask[igp_pkg::EV_W-1:0];
      end else if (wr && wb_adr_i[7:2] == igp_pkg::REG_IRQ_MASK[7:2]) begin
         if (wb_sel_i[0]) begin
            irq_mask_d = wb_dat_i[igp_pkg::EV_W-1:0];
         end
      end
      irq_stat_d = irq_stat_d | events;
      if (req && !wb_we_i) begin
         if (wb_adr_i[7:2] == igp_pkg::REG_CTRL[7:2]) begin
            dat_d = {31'h0, ctrl_en_q};
         end else if (wb_adr_i[7:2] == igp_pkg::REG_STATUS[7:2]) begin
            dat_d = status;
         end else if (wb_adr_i[7:2] == igp_pkg::REG_IRQ_STAT[7:2]) begin
            dat_d = {26'h0, irq_stat_q};
         end else if (wb_adr_i[7:2] == igp_pkg::REG_IRQ_MASK[7:2]) begin
            dat_d = {26'h0, irq_mask_q};
         end else begin
            // Unmapped addresses are acknowledged and read as zero.
            dat_d = 32'h0;
         end
      end
      irq_d = |(irq_stat_d & irq_mask_d);
   end

   // Register file flops.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_en_q  <= igp_pkg::CTRL_EN_RST;
         irq_mask_q <= igp_pkg::IRQ_MASK_RST;
         irq_stat_q <= '0;
         irq_q      <= 1'b0;
         dat_q      <= 32'h0;
         ack_q      <= 1'b0;
      end else begin
         ctrl_en_q  <= ctrl_en_d;
         irq_mask_q <= irq_mask_d;
         irq_stat_q <= irq_stat_d;
         irq_q      <= irq_d;
         dat_q      <= dat_d;
         ack_q      <= ack_d;
      end
   end

   // Outputs come straight from flops.
   assign gate_low_o       = gate_low_q;
   assign gate_high_o      = gate_high_q;
   assign fault_out_n_o    = fault_pin_q;
   assign fault_out_n_oe_o = fault_oe_q;
   assign irq_o            = irq_q;
   assign wb_dat_o         = dat_q;
   assign wb_ack_o         = ack_q;

endmodule
`default_nettype wire

/* File: verif/igp_props.sv */
// Concurrent checks on the pins of the inverter gate protection block.
`timescale 1ns/1ns
`default_nettype none
module igp_props (
   // Clock, reset and bus handshake
   input wire logic                       clk_i,
   input wire logic                       rst_i,
   input wire logic                       wb_cyc_i,
   input wire logic                       wb_stb_i,
   input wire logic                       wb_ack_o,
   // Commands and detector levels
   input wire logic [igp_pkg::PHASES-1:0] high_cmd_i,
   input wire logic [igp_pkg::PHASES-1:0] low_cmd_i,
   input wire logic                       short_circuit_trip_i,
   input wire logic                       low_supply_uv_i,
   input wire logic                       over_temp_trip_i,
   input wire logic [igp_pkg::PHASES-1:0] high_supply_uv_i,
   // Fault pin and gate drives
   input wire logic                       fault_out_n_o,
   input wire logic                       fault_out_n_oe_o,
   input wire logic [igp_pkg::PHASES-1:0] gate_high_o,
   input wire logic [igp_pkg::PHASES-1:0] gate_low_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic        ext_w;
   logic        det_w;
   logic [15:0] oe_cnt_q;
   logic [15:0] oe_cnt_d;
   // Extending and all fault-pin causes; high-side loss is deliberately not one of them.
   assign ext_w = low_supply_uv_i | over_temp_trip_i;
   assign det_w = ext_w | short_circuit_trip_i;
   // Length of the current fault pulse in cycles.
   always_comb begin
      oe_cnt_d = fault_out_n_oe_o ? oe_cnt_q + 16'h0001 : 16'h0000;
   end
   always_ff @(posedge clk_i) begin
      oe_cnt_q <= rst_i ? 16'h0000 : oe_cnt_d;
   end
   sc_low_off_a: assert property (short_circuit_trip_i |-> ##3 gate_low_o == '0)
      else $error("low gates on during short circuit");
   uv_ot_off_a: assert property (ext_w |-> ##3 gate_low_o == '0)
      else $error("low gates on during supply or thermal fault");
   hi_phase_off_a: assert property (|high_supply_uv_i |->
      ##3 (gate_high_o & $past(high_supply_uv_i, 3)) == '0)
      else $error("high gate on with its supply low");
   fault_cause_a: assert property ($rose(fault_out_n_oe_o) |-> $past(det_w, 3))
      else $error("fault pin rose without a low-side fault");
   pulse_min_a: assert property ($fell(fault_out_n_oe_o) |->
      oe_cnt_q >= igp_pkg::FAULT_MIN_CYC)
      else $error("fault pulse too short");
   pulse_fixed_a: assert property (oe_cnt_q > igp_pkg::FAULT_MIN_CYC + 4 |->
      $past(ext_w, 4) || $past(ext_w, 5))
      else $error("fault pulse stretched without cause");
   fault_hold_a: assert property (ext_w [*2] |-> ##2 fault_out_n_oe_o)
      else $error("fault pin released while condition lasts");
   open_drain_a: assert property (!fault_out_n_o)
      else $error("fault pin driven high");
   low_rearm_a: assert property (|(gate_low_o & ~$past(gate_low_o)) |->
      (gate_low_o & ~$past(gate_low_o) & ($past(low_cmd_i, 6) | ~$past(low_cmd_i))) == '0)
      else $error("low gate on without command edge");
   high_rearm_a: assert property (|(gate_high_o & ~$past(gate_high_o)) |->
      (gate_high_o & ~$past(gate_high_o) & ($past(high_cmd_i, 6) | ~$past(high_cmd_i))) == '0)
      else $error("high gate on without command edge");
   bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus ack not a single pulse");
   // Main scenarios seen.
   cover property (short_circuit_trip_i ##3 fault_out_n_oe_o);
   cover property ($fell(fault_out_n_oe_o) && oe_cnt_q > 16'hB54);
   cover property (|high_supply_uv_i);
endmodule
bind igp_top igp_props u_igp_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
   .high_cmd_i, .low_cmd_i, .short_circuit_trip_i, .low_supply_uv_i, .over_temp_trip_i,
   .high_supply_uv_i, .fault_out_n_o, .fault_out_n_oe_o, .gate_high_o, .gate_low_o);
`default_nettype wire

/* File: verif/igp_mcu_model.sv */
// Controller model: command drive with a blocking interval, and the pulled-up fault wire.
`timescale 1ns/1ns
`default_nettype none
module igp_mcu_model #(
   parameter int unsigned DEAD_CYC = 20
) (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Switch states asked for by the test sequence
   input  wire logic [2:0] high_req_i,
   input  wire logic [2:0] low_req_i,
   // Fault enable in, commands and wire level out
   input  wire logic       fault_oe_i,
   output logic      [2:0] high_cmd_o,
   output logic      [2:0] low_cmd_o,
   output logic            fault_n_o
);
   logic [2:0] high_q, high_d, low_q, low_d, ok;
   logic [7:0] idle_q [3];
   logic [7:0] idle_d [3];
   // Turn-off is at once; turn-on waits until the leg has idled long enough.
   always_comb begin
      for (int p = 0; p < 3; p++) begin
         ok[p] = idle_q[p] >= 8'(DEAD_CYC);
         idle_d[p] = (high_q[p] | low_q[p]) ? 8'h00 : idle_q[p] + {7'h00, !ok[p]};
         high_d[p] = high_req_i[p] & (high_q[p] | (!low_q[p] & ok[p]));
         low_d[p] = low_req_i[p] & !high_req_i[p] & (low_q[p] | (!high_q[p] & ok[p]));
      end
   end
   // Commands change just after an edge and are never left floating.
   always_ff @(posedge clk_i) begin
      high_q <= rst_i ? 3'h0 : high_d;
      low_q <= rst_i ? 3'h0 : low_d;
      for (int p = 0; p < 3; p++) begin
         idle_q[p] <= rst_i ? 8'h00 : idle_d[p];
      end
   end
   // The pull-up holds the wire high unless the block sinks it.
   assign high_cmd_o = high_q;
   assign low_cmd_o = low_q;
   assign fault_n_o = fault_oe_i ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking testbench for the inverter gate protection block.
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        wb_we_i = 1'b0;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_ack_o, fault_n, fault_out_n_o, fault_oe, irq_o;
   logic        sc_i = 1'b0;
   logic        luv_i = 1'b0;
   logic        ot_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o, rd;
   logic [2:0]  high_req = 3'h0;
   logic [2:0]  low_req = 3'h0;
   logic [2:0]  huv_i = 3'h0;
   logic [2:0]  high_cmd, low_cmd, gate_high_o, gate_low_o;
   logic [15:0] oe_w = 16'h0;
   logic [15:0] oe_last = 16'h0;
   int          num_errors = 0;
   int          checks = 0;
   always #4 clk_i = ~clk_i;
   // Design and controller model; the fault wire is resolved in the model.
   igp_top u_igp_top (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i(4'hF), .wb_we_i,
      .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .high_cmd_i(high_cmd), .low_cmd_i(low_cmd),
      .short_circuit_trip_i(sc_i), .low_supply_uv_i(luv_i), .over_temp_trip_i(ot_i),
      .high_supply_uv_i(huv_i), .fault_out_n_i(fault_n), .fault_out_n_o,
      .fault_out_n_oe_o(fault_oe), .gate_high_o, .gate_low_o, .irq_o);
   igp_mcu_model u_igp_mcu_model (.clk_i, .rst_i, .high_req_i(high_req), .low_req_i(low_req),
      .fault_oe_i(fault_oe), .high_cmd_o(high_cmd), .low_cmd_o(low_cmd), .fault_n_o(fault_n));
   // Width of the last fault pulse, in sampled cycles.
   always @(posedge clk_i) begin
      oe_w <= fault_oe ? oe_w + 16'h1 : 16'h0;
      if (!fault_oe && oe_w != 16'h0) begin
         oe_last <= oe_w;
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      if (num_errors == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // One classic cycle; the request stands until ack is sampled high.
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) begin
         num_errors++;
         results();
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   // Drops the low commands not in keep for 100 cycles, just over the 88-cycle minimum pulse, then all high.
   task automatic rearm(input logic [2:0] keep);
      low_req <= keep;
      tick(100);
      low_req <= 3'h7;
      tick(100);
   endtask
   // One low-side fault: gates, fault pulse, latched event and per-phase recovery.
   task automatic trip(input int k, input int hold);
      logic [2:0] det;
      int         w;
      int         lo;
      det = 3'h1 << k;
      w = 0;
      lo = (k != 0 && hold > 2500) ? hold : 2500;
      rearm(3'h0);
      check(gate_low_o, 3'h7);
      {ot_i, luv_i, sc_i} <= det;
      tick(20);
      check(gate_low_o, 3'h0);
      check(fault_n, 1'b0);
      check(fault_out_n_o, 1'b0);
      tick(hold - 20);
      {ot_i, luv_i, sc_i} <= 3'h0;
      while (fault_oe !== 1'b0 && w < 4000) begin
         @(posedge clk_i);
         w++;
      end
      // A pulse that never ends is a failure in its own right.
      if (w >= 4000) begin
         num_errors++;
         results();
      end
      tick(3);
      check(oe_last >= igp_pkg::FAULT_MIN_CYC && oe_last <= lo + 4, 1'b1);
      check(gate_low_o, 3'h0);
      wb(1'b0, igp_pkg::REG_IRQ_STAT, 32'h0);
      check(rd, {29'h0, det});
      check(irq_o, k != 0);
      wb(1'b1, igp_pkg::REG_IRQ_STAT, {29'h0, det});
      tick(2);
      check(irq_o, 1'b0);
      rearm(3'h6);
      check(gate_low_o, 3'h1);
   endtask
   initial begin
      repeat (60000) @(posedge clk_i);
      num_errors++;
      results();
   end
   // Reset values, then each protection in turn, then high-side loss on phase b.
   initial begin
      tick(20);
      rst_i <= 1'b0;
      check({gate_high_o, gate_low_o, fault_oe, irq_o}, 8'h00);
      wb(1'b0, igp_pkg::REG_CTRL, 32'h0);
      check(rd, 32'h0);
      wb(1'b0, igp_pkg::REG_IRQ_MASK, 32'h0);
      check(rd, {26'h0, igp_pkg::IRQ_MASK_RST});
      wb(1'b0, 8'h10, 32'h0);
      check(rd, 32'h0);
      // Idle status: every lock set, pin seen high, no condition live.
      wb(1'b0, igp_pkg::REG_STATUS, 32'h0);
      check(rd, 32'h00003F00);
      wb(1'b1, igp_pkg::REG_CTRL, 32'h1);
      for (int k = 0; k < 3; k++) begin
         if (k == 1) begin
            wb(1'b1, igp_pkg::REG_IRQ_MASK, 32'h3F);
         end
         trip(k, (k == 0) ? 2800 : ((k == 1) ? 3000 : 30));
      end
      low_req <= 3'h0;
      tick(100);
      high_req <= 3'h7;
      tick(100);
      check(gate_high_o, 3'h7);
      huv_i <= 3'h2;
      tick(20);
      check(gate_high_o, 3'h5);
      check(fault_oe, 1'b0);
      huv_i <= 3'h0;
      tick(100);
      check(gate_high_o, 3'h5);
      high_req <= 3'h5;
      tick(100);
      high_req <= 3'h7;
      tick(100);
      check(gate_high_o, 3'h7);
      wb(1'b0, igp_pkg::REG_IRQ_STAT, 32'h0);
      check(rd, 32'h1 << (igp_pkg::EV_HUV + 1));
      check(irq_o, 1'b1);
      results();
   end
endmodule
`default_nettype wire
